/* File: design/flash_ctl.sv */
`timescale 1ns/1ps
// Behaviour
// - Erase code written twice back to back; second write starts bulk erase.
// - Erase pulse timed ten milliseconds from the second erase write.
// - Erase-verify code ends the erase pulse and enters erase verification.
// - Every erase-verify write carries the byte address to check.
// - Wait a recovery delay after erase-verify before reading the byte.
// - All-ones byte is erased; on failure erase again, resume at that address.
// - At most one thousand erase pulses before declaring erase failure.
// - Program whole array to zeros before any erase pulse.
// - Interrupt during erase pulse waits until erase-verify is written.
// - Program set-up code makes the next write the byte to program.
// - Program write gives address and data; pulse starts at its strobe end.
// - Program-verify code ends the pulse; verify read needs no new address.
// - Keep intended byte; compare; match advances, mismatch reprograms.
// - Program pulse timed ten microseconds before program-verify.
// - At most twenty-five program pulses per byte before failure.
// - Interrupt during program pulse waits until program-verify is written.
// - All-ones code returns the device to read mode at algorithm end.
// - Wait at least one hundred nanoseconds of supply settle before commands.
// - Reads wait out the six microsecond recovery after each verify command.
// - Erase-verify follows every erase pulse, never skipped.
// - From program set-up, reset code is written twice.
module flash_ctl
  import flash_ctl_pkg::*;
#(
  parameter int unsigned ERASE_PULSE_CYCLES = ERASE_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start_erase,
  input wire logic start_prog,
  input wire logic [flash_ctl_pkg::ADDR_W-1:0] last_addr,
  input wire logic [7:0] prog_data,
  input wire logic irq_req,
  output logic irq_grant,
  output logic busy,
  output logic done,
  output logic fail,
  output logic prog_next,
  output logic [flash_ctl_pkg::ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_dout,
  output logic mem_doe,
  input wire logic [7:0] mem_din,
  output logic mem_we_n,
  output logic mem_oe_n,
  output logic mem_ce_n,
  output logic program_supply_high
);
  import flash_ctl_pkg::*;

  // Gray-coded states in declaration order.
  typedef enum logic [4:0] {
    S_IDLE = 5'h00, S_SETTLE = 5'h01, S_ZERO_SU = 5'h03, S_ZERO_PW = 5'h02,
    S_ZERO_PT = 5'h06, S_ZERO_VW = 5'h07, S_ZERO_RC = 5'h05, S_ZERO_RD = 5'h04,
    S_ER_SU = 5'h0C, S_ER_GO = 5'h0D, S_ER_PULSE = 5'h0F, S_EV_W = 5'h0E,
    S_EV_RC = 5'h0A, S_EV_RD = 5'h0B, S_PG_SU = 5'h09, S_PG_PW = 5'h08,
    S_PG_PT = 5'h18, S_PG_VW = 5'h19, S_PG_RC = 5'h1B, S_PG_RD = 5'h1A,
    S_PG_WAIT = 5'h1E, S_RST1 = 5'h1F, S_RST2 = 5'h1D, S_FIN = 5'h1C
  } state_e;

  // Bus op: 0 none, 1 write, 2 read. Each op lasts two phases of STROBE_CYC.
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;

  state_e state_reg, state_next;
  logic [31:0] tmr_reg, tmr_next;
  logic [10:0] ecnt_reg, ecnt_next;
  logic [4:0] pcnt_reg, pcnt_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next;
  logic mode_prog_reg, mode_prog_next;
  logic irq_grant_reg, irq_grant_next;
  logic done_reg, done_next, fail_reg, fail_next, pnext_reg, pnext_next;
  logic [1:0] op_reg, op_next;
  logic [3:0] ph_reg, ph_next;
  logic [7:0] wdat_reg, wdat_next;
  logic we_n_reg, we_n_next, oe_n_reg, oe_n_next, doe_reg, doe_next;
  logic vpp_reg, vpp_next;
  logic busy_reg, busy_next, ce_n_reg, ce_n_next;
  logic [7:0] rd_reg, rd_next;
  logic op_done;

  assign op_done = (op_reg != OP_NONE) && (ph_reg == 4'(2 * STROBE_CYC - 1));

  // The pulse only stops when the verify strobe rises, so the verify states still count.
  function automatic logic pulse_in_flight(input state_e s);
    return (s == S_ER_PULSE) || (s == S_PG_PT) || (s == S_ZERO_PT) ||
           (s == S_EV_W) || (s == S_PG_VW) || (s == S_ZERO_VW);
  endfunction

  always_comb begin
    state_next = state_reg;
    tmr_next = (tmr_reg != 32'h0000_0000) ? tmr_reg - 32'h0000_0001 : tmr_reg;
    ecnt_next = ecnt_reg;
    pcnt_next = pcnt_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    mode_prog_next = mode_prog_reg;
    done_next = 1'b0;
    fail_next = fail_reg;
    pnext_next = 1'b0;
    op_next = op_reg;
    ph_next = (op_reg != OP_NONE) ? ph_reg + 4'h1 : 4'h0;
    wdat_next = wdat_reg;
    rd_next = rd_reg;
    vpp_next = vpp_reg;
    // Interrupts are held off during any pulse so the verify write comes first.
    irq_grant_next = irq_req && !pulse_in_flight(state_reg) && op_reg == OP_NONE;
    // Strobe low in first phase: address set up before fall, data held to rise.
    we_n_next = !(op_reg == OP_WR && ph_next < 4'(STROBE_CYC));
    oe_n_next = !(op_reg == OP_RD && ph_next >= 4'(STROBE_CYC));
    doe_next = (op_reg == OP_WR);
    if (op_done) begin
      op_next = OP_NONE;
      ph_next = 4'h0;
      we_n_next = 1'b1;
      oe_n_next = 1'b1;
      doe_next = 1'b0;
      if (op_reg == OP_RD) begin
        rd_next = mem_din;
      end
    end
    case (state_reg)
      S_IDLE: begin
        if (start_erase || start_prog) begin
          mode_prog_next = start_prog && !start_erase;
          vpp_next = 1'b1;
          tmr_next = 32'(SUPPLY_SETTLE_CYC);
          fail_next = 1'b0;
          addr_next = ADDR_RST;
          ecnt_next = ERASE_CNT_RST;
          pcnt_next = PROG_CNT_RST;
          state_next = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (tmr_reg == 32'h0000_0000) begin
          state_next = mode_prog_reg ? S_PG_WAIT : S_ZERO_SU;
          data_next = DATA_ZERO;
        end
      end
      S_ZERO_SU, S_PG_SU: begin
        if (op_reg == OP_NONE && !op_done) begin
          op_next = OP_WR;
          wdat_next = CMD_PROG_SETUP;
        end else if (op_done) begin
          state_next = (state_reg == S_ZERO_SU) ? S_ZERO_PW : S_PG_PW;
        end
      end
      S_ZERO_PW, S_PG_PW: begin
        if (op_reg == OP_NONE && !op_done) begin
          op_next = OP_WR;
          wdat_next = data_reg;
          pcnt_next = pcnt_reg + 5'h01;
        end else if (op_done) begin
          tmr_next = 32'(PROG_PULSE_CYC);
          state_next = (state_reg == S_ZERO_PW) ? S_ZERO_PT : S_PG_PT;
        end
      end
      S_ZERO_PT, S_PG_PT: begin
        if (tmr_reg == 32'h0000_0000) begin
          state_next = (state_reg == S_ZERO_PT) ? S_ZERO_VW : S_PG_VW;
        end
      end
      S_ZERO_VW, S_PG_VW: begin
        if (op_reg == OP_NONE && !op_done) begin
          op_next = OP_WR;
          wdat_next = CMD_PROG_VERIFY;
        end else if (op_done) begin
          tmr_next = 32'(RECOVERY_CYC);
          state_next = (state_reg == S_ZERO_VW) ? S_ZERO_RC : S_PG_RC;
        end
      end
      S_ZERO_RC, S_PG_RC, S_EV_RC: begin
        if (tmr_reg == 32'h0000_0000) begin
          op_next = OP_RD;
          state_next = (state_reg == S_ZERO_RC) ? S_ZERO_RD
                     : (state_reg == S_PG_RC) ? S_PG_RD : S_EV_RD;
        end
      end
      S_ZERO_RD, S_PG_RD: begin
        if (op_done) begin
          if (mem_din == data_reg) begin
            pcnt_next = PROG_CNT_RST;
            if (state_reg == S_PG_RD) begin
              pnext_next = 1'b1;
              state_next = S_PG_WAIT;
            end else if (addr_reg == last_addr) begin
              addr_next = ADDR_RST;
              state_next = S_ER_SU;
            end else begin
              addr_next = addr_reg + 16'h0001;
              state_next = S_ZERO_SU;
            end
          end else if (pcnt_reg == 5'(MAX_PROG_PULSES)) begin
            fail_next = 1'b1;
            state_next = S_RST1;
          end else begin
            state_next = (state_reg == S_ZERO_RD) ? S_ZERO_SU : S_PG_SU;
          end
        end
      end
      S_PG_WAIT: begin
        // Caller supplies each byte; start_erase ends the programming run.
        if (start_prog) begin
          data_next = prog_data;
          addr_next = last_addr;
          state_next = S_PG_SU;
        end else if (start_erase) begin
          state_next = S_RST1;
        end
      end
      S_ER_SU, S_ER_GO: begin
        if (op_reg == OP_NONE && !op_done) begin
          op_next = OP_WR;
          wdat_next = CMD_ERASE;
          if (state_reg == S_ER_GO) begin
            ecnt_next = ecnt_reg + 11'h001;
          end
        end else if (op_done) begin
          state_next = (state_reg == S_ER_SU) ? S_ER_GO : S_ER_PULSE;
          if (state_reg == S_ER_GO) begin
            tmr_next = ERASE_PULSE_CYCLES;
          end
        end
      end
      S_ER_PULSE: begin
        if (tmr_reg == 32'h0000_0000) begin
          state_next = S_EV_W;
        end
      end
      S_EV_W: begin
        if (op_reg == OP_NONE && !op_done) begin
          op_next = OP_WR;
          wdat_next = CMD_ERASE_VERIFY;
        end else if (op_done) begin
          tmr_next = 32'(RECOVERY_CYC);
          state_next = S_EV_RC;
        end
      end
      S_EV_RD: begin
        if (op_done) begin
          if (mem_din == DATA_ERASED) begin
            if (addr_reg == last_addr) begin
              state_next = S_RST1;
            end else begin
              addr_next = addr_reg + 16'h0001;
              state_next = S_EV_W;
            end
          end else if (ecnt_reg == 11'(MAX_ERASE_PULSES)) begin
            fail_next = 1'b1;
            state_next = S_RST1;
          end else begin
            state_next = S_ER_SU;
          end
        end
      end
      S_RST1, S_RST2: begin
        if (op_reg == OP_NONE && !op_done) begin
          op_next = OP_WR;
          wdat_next = CMD_READ_RESET;
        end else if (op_done) begin
          state_next = (state_reg == S_RST1) ? S_RST2 : S_FIN;
        end
      end
      S_FIN: begin
        vpp_next = 1'b0;
        done_next = 1'b1;
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    busy_next = (state_next != S_IDLE);
    ce_n_next = !vpp_next;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= S_IDLE;
      tmr_reg <= 32'h0000_0000;
      ecnt_reg <= ERASE_CNT_RST;
      pcnt_reg <= PROG_CNT_RST;
      addr_reg <= ADDR_RST;
      data_reg <= 8'h00;
      mode_prog_reg <= 1'b0;
      irq_grant_reg <= 1'b0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      pnext_reg <= 1'b0;
      op_reg <= OP_NONE;
      ph_reg <= 4'h0;
      wdat_reg <= 8'h00;
      we_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      doe_reg <= 1'b0;
      vpp_reg <= 1'b0;
      rd_reg <= 8'h00;
      busy_reg <= 1'b0;
      ce_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      ecnt_reg <= ecnt_next;
      pcnt_reg <= pcnt_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      mode_prog_reg <= mode_prog_next;
      irq_grant_reg <= irq_grant_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      pnext_reg <= pnext_next;
      op_reg <= op_next;
      ph_reg <= ph_next;
      wdat_reg <= wdat_next;
      we_n_reg <= we_n_next;
      oe_n_reg <= oe_n_next;
      doe_reg <= doe_next;
      vpp_reg <= vpp_next;
      rd_reg <= rd_next;
      busy_reg <= busy_next;
      ce_n_reg <= ce_n_next;
    end
  end

  assign irq_grant = irq_grant_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign fail = fail_reg;
  assign prog_next = pnext_reg;
  assign mem_addr = addr_reg;
  assign mem_dout = wdat_reg;
  assign mem_doe = doe_reg;
  assign mem_we_n = we_n_reg;
  assign mem_oe_n = oe_n_reg;
  assign mem_ce_n = ce_n_reg;
  assign program_supply_high = vpp_reg;

  property p_strobe_low_only_with_supply;
    @(posedge clk_sys) disable iff (!nrst) !mem_we_n |-> program_supply_high;
  endproperty
  a_strobe_low_only_with_supply: assert property (p_strobe_low_only_with_supply)
    else $error("write strobe without program supply");

  property p_no_grant_in_pulse;
    @(posedge clk_sys) disable iff (!nrst) pulse_in_flight(state_reg) |=> !irq_grant;
  endproperty
  a_no_grant_in_pulse: assert property (p_no_grant_in_pulse)
    else $error("interrupt granted during pulse");

  property p_erase_goes_to_verify;
    @(posedge clk_sys) disable iff (!nrst)
      (state_reg == S_ER_PULSE && state_next != S_ER_PULSE) |=> state_reg == S_EV_W;
  endproperty
  a_erase_goes_to_verify: assert property (p_erase_goes_to_verify)
    else $error("erase pulse not followed by erase-verify");

  property p_recovery_before_read;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(state_reg == S_EV_RC) |-> (op_reg == OP_NONE) [*8];
  endproperty
  a_recovery_before_read: assert property (p_recovery_before_read)
    else $error("read started inside recovery");

  property p_erase_cmd_data;
    @(posedge clk_sys) disable iff (!nrst)
      (state_reg == S_ER_GO && !mem_we_n) |-> mem_dout == CMD_ERASE && mem_doe;
  endproperty
  a_erase_cmd_data: assert property (p_erase_cmd_data)
    else $error("second erase write carries wrong code");

  property p_erase_count_limit;
    @(posedge clk_sys) disable iff (!nrst) ecnt_reg <= 11'(MAX_ERASE_PULSES);
  endproperty
  a_erase_count_limit: assert property (p_erase_count_limit)
    else $error("erase pulse limit exceeded");

  property p_prog_count_limit;
    @(posedge clk_sys) disable iff (!nrst) pcnt_reg <= 5'(MAX_PROG_PULSES);
  endproperty
  a_prog_count_limit: assert property (p_prog_count_limit)
    else $error("program pulse limit exceeded");

  property p_settle_first;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(program_supply_high) |-> mem_we_n [*8];
  endproperty
  a_settle_first: assert property (p_settle_first)
    else $error("command before supply settled");

  c_erase_done: cover property (@(posedge clk_sys) disable iff (!nrst)
    done && !fail && !mode_prog_reg);
  c_prog_byte: cover property (@(posedge clk_sys) disable iff (!nrst) prog_next);
  c_fail: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(fail));
endmodule // flash_ctl

/* File: design/flash_ctl_pkg.sv */
package flash_ctl_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned ADDR_W = 16;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VERIFY = 8'hA0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_VERIFY = 8'hC0;
  localparam logic [7:0] CMD_READ_RESET = 8'hFF;
  localparam logic [7:0] DATA_ERASED = 8'hFF;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam int unsigned ERASE_PULSE_MS = 10;
  localparam int unsigned PROG_PULSE_US = 10;
  localparam int unsigned RECOVERY_US = 6;
  localparam int unsigned SUPPLY_SETTLE_NS = 100;
  localparam int unsigned ERASE_PULSE_CYC = ERASE_PULSE_MS * 1000 * CLK_MHZ;
  localparam int unsigned PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
  localparam int unsigned RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
  localparam int unsigned SUPPLY_SETTLE_CYC = (SUPPLY_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAX_ERASE_PULSES = 1000;
  localparam int unsigned MAX_PROG_PULSES = 25;
  localparam int unsigned STROBE_CYC = 4;
  localparam int unsigned BUS_PHASE_CYC = 8'd0 + STROBE_CYC;
  localparam logic [10:0] ERASE_CNT_RST = 11'h000;
  localparam logic [4:0] PROG_CNT_RST = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_LAST_DEF = 16'hFFFF;
endpackage

/* File: dv/flash_model.sv */
`timescale 1ns/1ps
module flash_model #(
  parameter int DEPTH = 8,
  parameter int ZERO_SPAN = 4,
  parameter int WEAK_ADDR = 1,
  parameter int STUCK_ADDR = 6,
  parameter realtime ERASE_NS = 250.0
) (
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_dout,
  input wire logic mem_doe,
  output logic [7:0] mem_din,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic mem_ce_n,
  input wire logic program_supply_high
);
  typedef enum logic [2:0] {RD, ESET, ERS, EVER, PSET, PRG, PVER} st_e;
  st_e st = RD;
  logic [7:0] mem [DEPTH];
  logic [7:0] pd = 8'h00;
  logic [7:0] rdv = 8'h00;
  int la = 0, pa = 0, erase_pulses = 0, prog_pulses = 0, viol = 0;
  realtime t_sup = 0, t_go = 0, t_ver = 0;
  bit weak_used = 0, in_erase = 0;
  wire pulsing = (st == ERS) || (st == PRG);
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // A released bus shows the inverse of the last read, so stale data never passes as valid.
  assign mem_din = (!mem_oe_n && !mem_ce_n) ? rdv : ~rdv;
  always @(posedge program_supply_high) t_sup = $realtime;
  always @(negedge mem_we_n) la = mem_addr % DEPTH;
  always @(negedge mem_oe_n) begin
    rdv = (st == EVER) ? mem[la] : (st == PVER) ? mem[pa] : mem[mem_addr % DEPTH];
    if ($realtime - t_ver < 6000.0) rdv = ~rdv;
  end
  always @(posedge mem_we_n) begin
    if (!mem_ce_n) begin
      if (!program_supply_high || !mem_doe || $realtime - t_sup < 100.0) viol++;
      else cmd(mem_dout);
    end
  end
  task automatic cmd(input logic [7:0] d);
    case (st)
      PSET: begin
        pa = la;
        pd = d;
        st = PRG;
        t_go = $realtime;
      end
      ESET: begin
        if (d == 8'h20) begin
          if (!in_erase) for (int i = 0; i < ZERO_SPAN; i++) if (mem[i] !== 8'h00) viol++;
          in_erase = 1;
          erase_pulses++;
          st = ERS;
          t_go = $realtime;
        end else st = RD;
      end
      ERS: begin
        if (d != 8'hA0 || $realtime - t_go < ERASE_NS) viol++;
        // The first pulse clears only byte 0, so verification meets a failing byte.
        else for (int i = 0; i < DEPTH; i++) if (erase_pulses > 1 || i < 1) mem[i] = 8'hFF;
        st = EVER;
        t_ver = $realtime;
      end
      PRG: begin
        if (d == 8'hC0) begin
          if ($realtime - t_go < 10000.0) viol++;
          else if (pa == WEAK_ADDR && !weak_used) weak_used = 1;
          else if (pa != STUCK_ADDR) mem[pa] = mem[pa] & pd;
          prog_pulses++;
          st = PVER;
          t_ver = $realtime;
        end else if (d == 8'hFF) st = RD;
        else viol++;
      end
      default: begin
        if (d == 8'h20) st = ESET;
        else if (d == 8'h40) st = PSET;
        else if (d == 8'hA0 && st == EVER) t_ver = $realtime;
        else if (d == 8'hFF) begin
          st = RD;
          in_erase = 0;
        end
      end
    endcase
  endtask
endmodule // flash_model

/* File: dv/test_flash_ctl.sv */
`timescale 1ns/1ps
module test_flash_ctl;
  import flash_ctl_pkg::*;
  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] m; int p;} row_s;
  row_s rows [2] = '{'{16'h0002, 8'hA5, 8'hA5, 1}, '{16'h0001, 8'h3C, 8'h3C, 2}};
  logic clk_sys = 0, nrst = 0, start_erase = 0, start_prog = 0, irq_req = 0;
  logic [ADDR_W-1:0] last_addr = 16'h0000;
  logic [7:0] prog_data = 8'h00;
  logic irq_grant, busy, done, fail, prog_next, mem_doe, mem_we_n, mem_oe_n, mem_ce_n;
  logic program_supply_high;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0] mem_dout, mem_din;
  int num_errors = 0, compares = 0, cycles = 0, grants = 0, p0 = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  flash_ctl #(.ERASE_PULSE_CYCLES(50)) i_flash_ctl (.clk_sys(clk_sys), .nrst(nrst),
    .start_erase(start_erase), .start_prog(start_prog), .last_addr(last_addr),
    .prog_data(prog_data), .irq_req(irq_req), .irq_grant(irq_grant), .busy(busy), .done(done),
    .fail(fail), .prog_next(prog_next), .mem_addr(mem_addr), .mem_dout(mem_dout),
    .mem_doe(mem_doe), .mem_din(mem_din), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
    .mem_ce_n(mem_ce_n), .program_supply_high(program_supply_high));
  flash_model #(.ZERO_SPAN(2), .ERASE_NS(250.0)) i_flash_model (.mem_addr(mem_addr),
    .mem_dout(mem_dout),
    .mem_doe(mem_doe), .mem_din(mem_din), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
    .mem_ce_n(mem_ce_n), .program_supply_high(program_supply_high));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wait_is(ref logic s, input logic v, input int lim);
    while (s !== v && lim > 0) begin
      @(negedge clk_sys);
      lim--;
    end
    check("handshake wait", 1, lim > 0);
  endtask
  task automatic send(input logic er, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    start_erase <= er;
    start_prog <= !er;
    last_addr <= a;
    prog_data <= d;
    @(posedge clk_sys);
    start_erase <= 1'b0;
    start_prog <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Granting an interrupt while a pulse runs would leave the array under stress.
  always @(negedge clk_sys) begin
    if (irq_grant === 1'b1) begin
      grants++;
      check("irq_grant during pulse", 0, i_flash_model.pulsing);
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 110000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    irq_req <= 1'b1;
    @(negedge clk_sys);
    check("busy", 0, busy);
    check("mem_we_n", 1, mem_we_n);
    check("mem_ce_n", 1, mem_ce_n);
    check("supply", 0, program_supply_high);
    $display("test reset done");
    send(1'b0, 16'h0000, 8'h00);
    repeat (25) @(posedge clk_sys);
    foreach (rows[i]) begin
      p0 = i_flash_model.prog_pulses;
      send(1'b0, rows[i].a, rows[i].d);
      wait_is(prog_next, 1'b1, 9000);
      check("byte", rows[i].m, i_flash_model.mem[rows[i].a]);
      check("pulses", rows[i].p, i_flash_model.prog_pulses - p0);
    end
    send(1'b1, 16'h0000, 8'h00);
    wait_is(done, 1'b1, 300);
    check("read mode", 0, i_flash_model.st);
    $display("test program rows done");
    send(1'b0, 16'h0000, 8'h00);
    repeat (25) @(posedge clk_sys);
    p0 = i_flash_model.prog_pulses;
    send(1'b0, 16'h0006, 8'h00);
    wait_is(fail, 1'b1, 90000);
    check("pulse limit", 25, i_flash_model.prog_pulses - p0);
    repeat (300) @(posedge clk_sys);
    if (busy === 1'b1) send(1'b1, 16'h0000, 8'h00);
    wait_is(busy, 1'b0, 300);
    $display("test program limit done");
    send(1'b1, 16'h0001, 8'h00);
    wait_is(done, 1'b1, 60000);
    check("fail", 0, fail);
    check("erase pulses", 2, i_flash_model.erase_pulses);
    for (int i = 0; i < 4; i++) check("erased", 8'hFF, i_flash_model.mem[i]);
    check("read mode", 0, i_flash_model.st);
    check("bus violations", 0, i_flash_model.viol);
    check("irq served", 1, grants > 0);
    $display("test erase done");
    give_verdict();
  end
endmodule // test_flash_ctl
